// ==== inc/fies_pkg.sv ====
// constants shared by the fuel injection event sequencer
package fies_pkg;

  // angle resolution: counts per degree of crank rotation
  localparam int ANG_PER_DEG = 128;
  // degrees in one engine cycle for each stroke mode
  localparam int DEG_CYCLE_2S = 360;
  localparam int DEG_CYCLE_4S = 720;
  // angle word width, wide enough for 720 * 128 counts
  localparam int ANG_W = 17;
  localparam logic [ANG_W-1:0] ANG_CYCLE_2S = ANG_W'(DEG_CYCLE_2S * ANG_PER_DEG);
  localparam logic [ANG_W-1:0] ANG_CYCLE_4S = ANG_W'(DEG_CYCLE_4S * ANG_PER_DEG);
  localparam logic [ANG_W-1:0] ANG_RST = 17'h0_0000;

  // cylinders, shared lines and cylinder index width
  localparam int CYL_NUM = 20;
  localparam int LINE_NUM = 10;
  localparam int CYL_W = 5;

  // tooth period counter width in mclk cycles
  localparam int PER_W = 20;
  localparam logic [PER_W-1:0] PER_MAX = 20'hF_FFFF;
  localparam logic [PER_W-1:0] PER_RST = 20'hF_FFFF;

  // default speed wheel tooth count
  localparam int TEETH_DEF = 60;

  // which cylinder of a line's pair is pending next
  typedef enum logic [1:0] {
    FIES_PEND_LO = 2'b01,
    FIES_PEND_HI = 2'b10
  } fies_pend_t;

endpackage

// ==== src/fies_sequencer.sv ====
// angle based fuel injection event sequencer
`timescale 1ns/1ps
`default_nettype none

module fies_sequencer
  import fies_pkg::*;
#(
  parameter int TEETH = TEETH_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic speed_tooth_in,
  input wire logic top_centre_pulse_in,
  input wire logic phase_pulse_in,
  input wire logic four_stroke_mode,
  input wire logic ang_wr_en,
  input wire logic [CYL_W-1:0] ang_wr_cyl,
  input wire logic [ANG_W-1:0] injection_start_angle,
  input wire logic [ANG_W-1:0] injection_end_angle,
  output logic [CYL_NUM-1:0] fire,
  output logic [LINE_NUM-1:0] inj_line,
  output logic cycle_ref_mark,
  output logic angle_valid,
  output logic [ANG_W-1:0] crank_angle
);

  // counts of angle per speed tooth
  localparam logic [ANG_W-1:0] ANG_PER_TOOTH = ANG_W'((DEG_CYCLE_2S * ANG_PER_DEG) / TEETH);

  // reset release
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // pin synchronisers and agreement filter for the three sensor inputs
  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] lvl_ff;
  logic [2:0] rise;
  assign pin_raw = {phase_pulse_in, top_centre_pulse_in, speed_tooth_in};

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pin
      always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          sync1_ff[p] <= 1'b0;
          sync2_ff[p] <= 1'b0;
          sync3_ff[p] <= 1'b0;
          lvl_ff[p] <= 1'b0;
        end else begin
          sync1_ff[p] <= pin_raw[p];
          sync2_ff[p] <= sync1_ff[p];
          sync3_ff[p] <= sync2_ff[p];
          if (sync2_ff[p] == sync3_ff[p]) begin
            lvl_ff[p] <= sync3_ff[p];
          end
        end
      end
      assign rise[p] = (sync2_ff[p] == sync3_ff[p]) && sync3_ff[p] && !lvl_ff[p];
    end
  endgenerate

  logic tooth_ev;
  logic tdc_ev;
  logic phase_ev;
  assign tooth_ev = rise[0];
  assign tdc_ev = rise[1];
  assign phase_ev = rise[2];

  // reference mark qualification
  logic armed_ff;
  logic ref_ev;
  assign ref_ev = tdc_ev && (!four_stroke_mode || armed_ff);

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      armed_ff <= 1'b0;
    end else if (!four_stroke_mode) begin
      armed_ff <= 1'b0;
    end else if (phase_ev) begin
      armed_ff <= 1'b1;
    end else if (tdc_ev) begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cycle_ref_mark <= 1'b0;
    end else begin
      cycle_ref_mark <= ref_ev;
    end
  end

  // tooth period measurement
  // tooth period in clocks
  logic [PER_W-1:0] per_cnt_ff;
  logic [PER_W-1:0] per_last_ff;
  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      per_cnt_ff <= PER_RST;
      per_last_ff <= PER_RST;
    end else if (tooth_ev) begin
      per_last_ff <= per_cnt_ff;
      per_cnt_ff <= PER_W'(1);
    end else if (per_cnt_ff != PER_MAX) begin
      per_cnt_ff <= per_cnt_ff + PER_W'(1);
    end
  end

  // interpolating angle counter
  logic [ANG_W-1:0] cycle_len;
  logic [ANG_W-1:0] tooth_base_ff;
  logic [ANG_W-1:0] angle_ff;
  logic [PER_W:0] acc_ff;
  logic [PER_W:0] acc_sum;
  logic step;
  logic [ANG_W-1:0] nxt_base;
  assign cycle_len = four_stroke_mode ? ANG_CYCLE_4S : ANG_CYCLE_2S;
  assign acc_sum = acc_ff + (PER_W+1)'(ANG_PER_TOOTH);
  assign step = (acc_sum >= {1'b0, per_last_ff}) &&
                (angle_ff < tooth_base_ff + ANG_PER_TOOTH - ANG_W'(1));
  assign nxt_base = (tooth_base_ff + ANG_PER_TOOTH >= cycle_len) ? ANG_RST :
                    tooth_base_ff + ANG_PER_TOOTH;

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tooth_base_ff <= ANG_RST;
      angle_ff <= ANG_RST;
      acc_ff <= '0;
    end else if (ref_ev) begin
      tooth_base_ff <= ANG_RST;
      angle_ff <= ANG_RST;
      acc_ff <= '0;
    end else if (tooth_ev) begin
      tooth_base_ff <= nxt_base;
      angle_ff <= nxt_base;
      acc_ff <= '0;
    end else if (step) begin
      angle_ff <= angle_ff + ANG_W'(1);
      acc_ff <= acc_sum - {1'b0, per_last_ff};
    end else if (acc_sum < {1'b0, per_last_ff}) begin
      acc_ff <= acc_sum;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      angle_valid <= 1'b0;
    end else if (ref_ev) begin
      angle_valid <= 1'b1;
    end
  end
  assign crank_angle = angle_ff;

  // per-cylinder angle table written by the host
  logic [ANG_W-1:0] start_ang_ff [CYL_NUM];
  logic [ANG_W-1:0] end_ang_ff [CYL_NUM];
  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < CYL_NUM; i++) begin
        start_ang_ff[i] <= ANG_RST;
        end_ang_ff[i] <= ANG_RST;
      end
    end else if (ang_wr_en && (ang_wr_cyl < CYL_W'(CYL_NUM))) begin
      start_ang_ff[ang_wr_cyl] <= injection_start_angle;
      end_ang_ff[ang_wr_cyl] <= injection_end_angle;
    end
  end

  // shared line engines, line l serves cylinders l and l+LINE_NUM
  logic fire_lo_ff [LINE_NUM];
  logic fire_hi_ff [LINE_NUM];
  logic line_ff [LINE_NUM];
  fies_pend_t pend_ff [LINE_NUM];
  logic [ANG_W-1:0] end_ld_ff [LINE_NUM];

  genvar l;
  generate
    for (l = 0; l < LINE_NUM; l++) begin : g_line
      logic [ANG_W-1:0] cur_start;
      logic [ANG_W-1:0] cur_end;
      logic hit_start;
      logic hit_end;
      assign cur_start = (pend_ff[l] == FIES_PEND_HI) ? start_ang_ff[l+LINE_NUM] : start_ang_ff[l];
      assign cur_end = (pend_ff[l] == FIES_PEND_HI) ? end_ang_ff[l+LINE_NUM] : end_ang_ff[l];
      assign hit_start = angle_valid && !line_ff[l] && (angle_ff == cur_start);
      assign hit_end = line_ff[l] && (angle_ff == end_ld_ff[l]);

      always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          line_ff[l] <= 1'b0;
          pend_ff[l] <= FIES_PEND_LO;
          end_ld_ff[l] <= ANG_RST;
          fire_lo_ff[l] <= 1'b0;
          fire_hi_ff[l] <= 1'b0;
        end else if (hit_start) begin
          line_ff[l] <= 1'b1;
          end_ld_ff[l] <= cur_end;
          fire_lo_ff[l] <= (pend_ff[l] == FIES_PEND_LO);
          fire_hi_ff[l] <= (pend_ff[l] == FIES_PEND_HI);
        end else if (hit_end) begin
          line_ff[l] <= 1'b0;
          fire_lo_ff[l] <= 1'b0;
          fire_hi_ff[l] <= 1'b0;
          pend_ff[l] <= (pend_ff[l] == FIES_PEND_HI) ? FIES_PEND_LO : FIES_PEND_HI;
        end
      end

      assign inj_line[l] = line_ff[l];
      // output l is line l low side
      assign fire[l] = fire_lo_ff[l];
      assign fire[l+LINE_NUM] = fire_hi_ff[l];
    end
  endgenerate

endmodule

`default_nettype wire

// ==== sim/fies_sequencer_asserts.sv ====
// port assertions for the injection event sequencer
`timescale 1ns/1ps
`default_nettype none
module fies_sequencer_asserts
  import fies_pkg::*;
#(
  parameter int TEETH = TEETH_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic four_stroke_mode,
  input wire logic [CYL_NUM-1:0] fire,
  input wire logic [LINE_NUM-1:0] inj_line,
  input wire logic cycle_ref_mark,
  input wire logic angle_valid,
  input wire logic [ANG_W-1:0] crank_angle
);
  localparam int CPT = DEG_CYCLE_2S * ANG_PER_DEG / TEETH;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_mark_one_cycle: assert property (cycle_ref_mark |=> !cycle_ref_mark)
    else $error("mark too long");
  a_mark_zero_angle: assert property (cycle_ref_mark |-> crank_angle <= 17'h0_0001)
    else $error("angle not zeroed");
  a_valid_from_mark: assert property ($rose(angle_valid) |-> cycle_ref_mark)
    else $error("valid without mark");
  a_valid_stays: assert property (angle_valid |=> angle_valid)
    else $error("valid dropped");
  a_line_merge: assert property (inj_line == (fire[LINE_NUM-1:0] | fire[CYL_NUM-1:LINE_NUM]))
    else $error("line differs");
  a_pair_apart: assert property ((fire[LINE_NUM-1:0] & fire[CYL_NUM-1:LINE_NUM]) == '0)
    else $error("pair overlap");
  a_fire_needs_valid: assert property (|fire |-> angle_valid)
    else $error("fire before valid");
  a_angle_in_cycle: assert property (crank_angle < (four_stroke_mode ? ANG_CYCLE_4S : ANG_CYCLE_2S))
    else $error("angle too big");
  a_angle_step: assert property (crank_angle > $past(crank_angle) |-> crank_angle - $past(crank_angle) <= CPT)
    else $error("angle jump");
  c_mark: cover property (cycle_ref_mark);
  c_fire_low: cover property ($rose(fire[0]));
  c_fire_high: cover property ($fell(|fire[CYL_NUM-1:LINE_NUM]));
endmodule
`default_nettype wire

// ==== sim/fies_host_model.sv ====
// host model writing every cylinder's angle pair
`timescale 1ns/1ps
`default_nettype none
module fies_host_model
  import fies_pkg::*;
(
  input wire logic mclk,
  input wire logic run,
  input wire logic [ANG_W-1:0] base,
  input wire logic [ANG_W-1:0] gap,
  input wire logic [ANG_W-1:0] dur,
  output logic ang_wr_en,
  output logic [CYL_W-1:0] ang_wr_cyl,
  output logic [ANG_W-1:0] injection_start_angle,
  output logic [ANG_W-1:0] injection_end_angle
);
  logic [CYL_W-1:0] cnt_ff = 5'h14;
  always @(posedge mclk) cnt_ff <= run ? 5'h00 : cnt_ff + 5'(cnt_ff != 5'h14);
  assign ang_wr_en = cnt_ff != 5'h14;
  assign ang_wr_cyl = cnt_ff;
  assign injection_start_angle = base + ANG_W'(16 * (cnt_ff % 10)) + (cnt_ff > 5'h09 ? gap : '0);
  assign injection_end_angle = injection_start_angle + (dur < gap ? dur : gap - 17'h0_0001);
endmodule
`default_nettype wire

// ==== sim/fuel_injection_event_sequencer_tb_top.sv ====
// self-checking bench for the injection event sequencer
`timescale 1ns/1ps
`default_nettype none
module fuel_injection_event_sequencer_tb_top;
  import fies_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic tooth = 1'b0;
  logic top_centre_pulse = 1'b0;
  logic phase = 1'b0;
  logic mode = 1'b1;
  logic run = 1'b0;
  logic wr_en;
  logic [CYL_W-1:0] wr_cyl;
  logic [ANG_W-1:0] base = '0, gap = '0, dur = '0, st, en, ang, prev;
  logic [CYL_NUM-1:0] fire;
  logic [LINE_NUM-1:0] line;
  logic mark;
  logic valid;
  int seed = 8422;
  int mismatches = 0;
  int checks_done = 0;
  int marks = 0;
  int tc = 0;
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    tc <= (tc == 767) ? 0 : tc + 1;
    tooth <= tc < 8;
    if (mark === 1'b1) marks <= marks + 1;
  end
  fies_sequencer dut (.mclk(mclk), .reset_n(reset_n), .speed_tooth_in(tooth), .top_centre_pulse_in(top_centre_pulse),
    .phase_pulse_in(phase), .four_stroke_mode(mode), .ang_wr_en(wr_en), .ang_wr_cyl(wr_cyl),
    .injection_start_angle(st), .injection_end_angle(en), .fire(fire), .inj_line(line),
    .cycle_ref_mark(mark), .angle_valid(valid), .crank_angle(ang));
  fies_host_model u_host (.mclk(mclk), .run(run), .base(base), .gap(gap), .dur(dur), .ang_wr_en(wr_en),
    .ang_wr_cyl(wr_cyl), .injection_start_angle(st), .injection_end_angle(en));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [ANG_W-1:0] exp_start(input int c);
    return base + ANG_W'(16 * (c % LINE_NUM)) + ((c >= LINE_NUM) ? gap : '0);
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic pulse(input logic is_tdc);
    @(posedge mclk);
    for (int i = 0; i < 800 && tc != 0; i++) @(posedge mclk);
    if (tc != 0) begin
      mismatches++;
      summarize();
    end
    @(posedge mclk);
    if (is_tdc) top_centre_pulse <= 1'b1; else phase <= 1'b1;
    repeat (8) @(posedge mclk);
    top_centre_pulse <= 1'b0;
    phase <= 1'b0;
  endtask
  task automatic host_run(input logic [ANG_W-1:0] d);
    @(posedge mclk);
    dur <= d;
    run <= 1'b1;
    @(posedge mclk);
    run <= 1'b0;
    repeat (21) @(posedge mclk);
  endtask
  task automatic watch(input int c, input logic lvl, input logic [ANG_W-1:0] exp);
    for (int i = 0; i < 5000; i++) begin
      @(posedge mclk);
      #1;
      if (fire[c] === lvl) begin
        cmp(prev, exp);
        cmp(line[c % LINE_NUM], lvl);
        return;
      end
      prev = ang;
    end
    mismatches++;
    summarize();
  endtask
  task automatic fire_case(input int ln, input logic m);
    logic [ANG_W-1:0] s, d2, d3;
    int k;
    @(posedge mclk);
    mode <= m;
    base <= 17'(832 + ($random(seed) & 255));
    gap <= 17'(768 * (1 + ($random(seed) & 1)));
    d2 = 17'(64 + ($random(seed) & 127));
    d3 = 17'(64 + ($random(seed) & 127));
    host_run(17'h0_0040);
    pulse(1'b0);
    pulse(1'b1);
    cmp(valid, 1'b1);
    host_run(d2);
    s = exp_start(ln);
    watch(ln, 1'b1, s);
    host_run(d3);
    watch(ln, 1'b0, s + d2);
    watch(ln + 10, 1'b1, exp_start(ln + 10));
    watch(ln + 10, 1'b0, exp_start(ln + 10) + d3);
    for (k = 0; k < 3000 && !(ang > s + gap + 17'h0_0190 && fire === '0); k++) @(posedge mclk);
    if (k == 3000) begin
      mismatches++;
      summarize();
    end
    $display("fire case done");
  endtask
  task automatic mark_case(input logic m, input logic ph, input int exp);
    int m0;
    @(posedge mclk);
    mode <= m;
    m0 = marks;
    if (ph) pulse(1'b0);
    pulse(1'b1);
    repeat (8) @(posedge mclk);
    cmp(marks - m0, exp);
    $display("mark case done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    host_run(17'h0_0040);
    pulse(1'b0);
    pulse(1'b0);
    fire_case(0, 1'b1);
    for (int i = 1; i < 4; i++) fire_case($unsigned($random(seed)) % 10, i != 1);
    mark_case(1'b1, 1'b0, 0);
    mark_case(1'b1, 1'b1, 1);
    mark_case(1'b1, 1'b0, 0);
    mark_case(1'b0, 1'b0, 1);
    summarize();
  end
endmodule
bind fies_sequencer fies_sequencer_asserts #(.TEETH(TEETH)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .four_stroke_mode(four_stroke_mode), .fire(fire), .inj_line(inj_line), .cycle_ref_mark(cycle_ref_mark),
  .angle_valid(angle_valid), .crank_angle(crank_angle));
`default_nettype wire
